// File: hw/obcd_top.sv
// Option byte configuration decoder top
`timescale 1ns/10ps
`default_nettype none
`include "obcd_consts.svh"
module obcd_top
  import obcd_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // Option bytes from storage
  input  wire logic [7:0] i_readout_protect_byte,
  input  wire logic [7:0] i_boot_area_protect_byte,
  input  wire logic [7:0] i_pin_remap_byte,
  // Option byte rewrite request
  input  wire logic       i_wr_req,
  input  wire logic [1:0] i_wr_sel,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_wr_via_debug,
  // Write toward storage
  output logic            o_nv_wr_en,
  output logic [1:0]      o_nv_wr_sel,
  output logic [7:0]      o_nv_wr_data,
  output logic            o_wr_refused,
  // Captured bytes and state
  output logic            o_config_valid,
  output logic [7:0]      o_readout_protect_byte,
  output logic [7:0]      o_boot_area_protect_byte,
  output logic [7:0]      o_pin_remap_byte,
  // Memory protection
  output logic            o_readout_lock,
  output logic            o_boot_area_en,
  output logic [5:0]      o_boot_last_page,
  input  wire logic [5:0] i_page,
  output logic            o_page_write_protected,
  // Pin multiplexer selects
  output logic            o_pd4_tone_sel,
  output logic            o_pb54_i2c_sel,
  output logic            o_pb30_timer_one_sel,
  output logic            o_pd0_clock_out_sel,
  output logic            o_remap_two_active,
  output logic            o_remap_three_active,
  output logic            o_pa3_d2_swap,
  output logic            o_remap_bit_zero
);
  // Reset release through two flops
  logic        rst_s1_reg;
  logic        rst_sync_n;
  obcd_state_e state_reg;
  obcd_state_e state_next;
  obcd_byte_t  readout_reg;
  obcd_byte_t  boot_reg;
  obcd_byte_t  remap_reg;
  logic        lock_reg;
  logic        two_act_reg;
  logic        three_act_reg;
  logic        nv_en_reg;
  logic [1:0]  nv_sel_reg;
  obcd_byte_t  nv_data_reg;
  logic        refused_reg;
  logic        page_prot_reg;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_s1_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_sync_n <= rst_s1_reg;
    end
  end

  // Capture happens once, in the first cycle after release
  wire logic loading;
  assign loading    = (state_reg == OBCD_ST_LOAD);
  assign state_next = OBCD_ST_RUN;

  always_ff @(posedge i_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg <= OBCD_ST_LOAD;
    end else begin
      state_reg <= state_next;
    end
  end

  // Decoded values stay frozen until the next reset
  always_ff @(posedge i_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      readout_reg   <= `OBCD_BYTE_RESET;
      boot_reg      <= `OBCD_BYTE_RESET;
      remap_reg     <= `OBCD_BYTE_RESET;
      lock_reg      <= 1'b0;
      two_act_reg   <= 1'b0;
      three_act_reg <= 1'b0;
    end else if (loading) begin
      readout_reg   <= i_readout_protect_byte;
      boot_reg      <= i_boot_area_protect_byte;
      remap_reg     <= i_pin_remap_byte;
      lock_reg      <= (i_readout_protect_byte == `OBCD_READOUT_ENABLE);
      two_act_reg   <= i_pin_remap_byte[`OBCD_REMAP_TWO];
      three_act_reg <= i_pin_remap_byte[`OBCD_REMAP_THREE]
                       && !i_pin_remap_byte[`OBCD_REMAP_TWO];
    end
  end

  // Locked parts accept rewrites from the debug path only
  wire logic wr_take;
  wire logic wr_refuse;
  wire logic wr_accept;
  assign wr_take   = i_wr_req && !loading;
  assign wr_refuse = wr_take && lock_reg && !i_wr_via_debug;
  assign wr_accept = wr_take && !wr_refuse;

  always_ff @(posedge i_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      nv_en_reg   <= 1'b0;
      nv_sel_reg  <= 2'h0;
      nv_data_reg <= `OBCD_BYTE_RESET;
      refused_reg <= 1'b0;
    end else begin
      nv_en_reg   <= wr_accept;
      refused_reg <= wr_refuse;
      if (wr_accept) begin
        nv_sel_reg  <= i_wr_sel;
        nv_data_reg <= i_wr_data;
      end
    end
  end

  // Boot area decode
  wire logic       area_en_w;
  wire obcd_page_t last_page_w;
  wire logic       page_prot_w;

  obcd_boot_decode u_boot (
    .i_field          (boot_reg[`OBCD_BOOT_MSB:0]),
    .i_page           (i_page),
    .o_area_en        (area_en_w),
    .o_last_page      (last_page_w),
    .o_page_protected (page_prot_w)
  );

  // Query answer lags the page by one cycle
  always_ff @(posedge i_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      page_prot_reg <= 1'b0;
    end else begin
      page_prot_reg <= page_prot_w && !loading;
    end
  end

  assign o_nv_wr_en               = nv_en_reg;
  assign o_nv_wr_sel              = nv_sel_reg;
  assign o_nv_wr_data             = nv_data_reg;
  assign o_wr_refused             = refused_reg;
  assign o_config_valid           = !loading;
  assign o_readout_protect_byte   = readout_reg;
  assign o_boot_area_protect_byte = boot_reg;
  assign o_pin_remap_byte         = remap_reg;
  assign o_readout_lock           = lock_reg;
  assign o_boot_area_en           = area_en_w;
  assign o_boot_last_page         = last_page_w;
  assign o_page_write_protected   = page_prot_reg;
  assign o_pd4_tone_sel           = remap_reg[`OBCD_REMAP_SEVEN];
  assign o_pb54_i2c_sel           = remap_reg[`OBCD_REMAP_SIX];
  assign o_pb30_timer_one_sel     = remap_reg[`OBCD_REMAP_FIVE];
  assign o_pd0_clock_out_sel      = remap_reg[`OBCD_REMAP_FOUR];
  assign o_remap_two_active       = two_act_reg;
  assign o_remap_three_active     = three_act_reg;
  assign o_pa3_d2_swap            = remap_reg[`OBCD_REMAP_ONE];
  assign o_remap_bit_zero         = remap_reg[`OBCD_REMAP_ZERO];

  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_sync_n);

  property p_lock_capture;
    loading |=> (o_readout_lock ==
                 ($past(i_readout_protect_byte) == `OBCD_READOUT_ENABLE));
  endproperty
  a_lock_capture: assert property (p_lock_capture)
    else $error("readout lock does not follow captured byte");

  property p_refuse;
    (wr_take && o_readout_lock && !i_wr_via_debug)
      |=> (o_wr_refused && !o_nv_wr_en);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("locked non-debug write not refused");

  property p_debug_write;
    (wr_take && i_wr_via_debug)
      |=> (o_nv_wr_en && !o_wr_refused && o_nv_wr_data == $past(i_wr_data));
  endproperty
  a_debug_write: assert property (p_debug_write)
    else $error("debug write not passed to storage");

  property p_boot_none;
    (o_config_valid && boot_reg[5:0] == 6'h00)
      |-> (!o_boot_area_en ##1 !o_page_write_protected);
  endproperty
  a_boot_none: assert property (p_boot_none)
    else $error("protection present with empty boot field");

  // Written as or-terms so the two cases cannot bind into one implication
  property p_boot_small;
    o_config_valid
      |-> ((boot_reg[5:0] != 6'h01) || (o_boot_last_page == 6'h01))
          && ((boot_reg[5:0] != 6'h02) || (o_boot_last_page == 6'h03));
  endproperty
  a_boot_small: assert property (p_boot_small)
    else $error("small boot area size wrong");

  property p_boot_grow;
    (o_config_valid && boot_reg[5:0] >= 6'h03)
      |-> (o_boot_area_en && o_boot_last_page >= 6'h05
           && (boot_reg[5:0] != 6'h3F || o_boot_last_page == 6'h3F));
  endproperty
  a_boot_grow: assert property (p_boot_grow)
    else $error("large boot area size wrong");

  property p_page_query;
    (o_config_valid && o_boot_area_en && i_page <= o_boot_last_page)
      |=> o_page_write_protected;
  endproperty
  a_page_query: assert property (p_page_query)
    else $error("page inside boot area not protected");

  property p_remap_high;
    loading |=> (o_pd4_tone_sel == $past(i_pin_remap_byte[7]))
             && (o_pb54_i2c_sel == $past(i_pin_remap_byte[6]))
             && (o_pb30_timer_one_sel == $past(i_pin_remap_byte[5]));
  endproperty
  a_remap_high: assert property (p_remap_high)
    else $error("upper remap selects wrong");

  property p_remap_d0;
    loading |=> (o_pd0_clock_out_sel == $past(i_pin_remap_byte[4]));
  endproperty
  a_remap_d0: assert property (p_remap_d0)
    else $error("port D0 select wrong");

  property p_priority;
    o_config_valid |-> !(o_remap_two_active && o_remap_three_active)
      && (o_remap_two_active == o_pin_remap_byte[2]);
  endproperty
  a_priority: assert property (p_priority)
    else $error("remap bit three not overridden");

  property p_swap;
    loading |=> (o_pa3_d2_swap == $past(i_pin_remap_byte[1]));
  endproperty
  a_swap: assert property (p_swap)
    else $error("channel swap select wrong");

  property p_hold;
    (o_config_valid && $past(o_config_valid))
      |-> ($stable(o_readout_lock) && $stable(o_pin_remap_byte)
           && $stable(o_boot_area_protect_byte));
  endproperty
  a_hold: assert property (p_hold)
    else $error("decoded settings changed after capture");

  c_locked: cover property (loading ##1 o_readout_lock);
  c_refused: cover property (o_wr_refused);
  c_debug_write: cover property (o_readout_lock && o_nv_wr_en);
  c_both_remap: cover property (loading ##1 o_pin_remap_byte[3:2] == 2'h3);
endmodule
`default_nettype wire

// File: hw/obcd_consts.svh
// Constants for the option byte configuration decoder
// Operation
// - A readout protect byte equal to the enable code turns readout lock on, and then only the single-wire debug path may rewrite option bytes.
// - The boot code area field is bits 5 to 0, and zero means no boot area and no program memory write protection.
// - Field value one protects pages 0 to 1 and field value two protects pages 0 to 3.
// - Field values three to the maximum protect progressively larger areas, up to page 63.
// - Remap bit seven clear routes timer two channel one to D4, set routes the tone output there.
// - Remap bit six clear gives B5 and B4 to analog inputs, set gives them I2C data and clock.
// - Remap bit five clear gives B3 to B0 to analog inputs, set gives timer one trigger and complementary outputs.
// - The remap bit governing D0 selects timer three channel two when clear and the clock output when set.
// - With remap bits two and three both set, bit two applies and bit three is ignored on shared pins.
// - Remap bit one set swaps the timer channels on A3 and D2, so A3 carries timer three channel one.
`ifndef OBCD_CONSTS_SVH
`define OBCD_CONSTS_SVH

`define OBCD_READOUT_ENABLE 8'hAA
`define OBCD_BYTE_RESET     8'h00
`define OBCD_SEL_READOUT    2'h0
`define OBCD_SEL_BOOT       2'h1
`define OBCD_SEL_REMAP      2'h2
`define OBCD_BOOT_MSB       5
`define OBCD_BOOT_NONE      6'h00
`define OBCD_BOOT_HALF      6'h20
`define OBCD_PAGE_LAST      6'h3F
`define OBCD_REMAP_SEVEN    7
`define OBCD_REMAP_SIX      6
`define OBCD_REMAP_FIVE     5
`define OBCD_REMAP_FOUR     4
`define OBCD_REMAP_THREE    3
`define OBCD_REMAP_TWO      2
`define OBCD_REMAP_ONE      1
`define OBCD_REMAP_ZERO     0

`endif

// File: hw/obcd_pkg.sv
// Types for the option byte configuration decoder
`default_nettype none
package obcd_pkg;
  typedef enum logic [1:0] {
    OBCD_ST_LOAD = 2'b01,
    OBCD_ST_RUN  = 2'b10
  } obcd_state_e;
  typedef logic [7:0] obcd_byte_t;
  typedef logic [5:0] obcd_page_t;
endpackage
`default_nettype wire

// File: hw/obcd_boot_decode.sv
// Boot code area decode from the six-bit field
`timescale 1ns/10ps
`default_nettype none
`include "obcd_consts.svh"
module obcd_boot_decode
  import obcd_pkg::*;
(
  // Field and page query
  input  wire logic [5:0] i_field,
  input  wire logic [5:0] i_page,
  // Decoded area
  output logic            o_area_en,
  output logic [5:0]      o_last_page,
  output logic            o_page_protected
);
  // Last page is 2*v-1, saturating at the top page
  function automatic obcd_page_t last_page(input obcd_page_t v);
    logic [6:0] dbl;
    dbl = {v, 1'b0} - 7'h01;
    if (v == `OBCD_BOOT_NONE) begin
      last_page = 6'h00;
    end else if (v >= `OBCD_BOOT_HALF) begin
      last_page = `OBCD_PAGE_LAST;
    end else begin
      last_page = dbl[5:0];
    end
  endfunction

  wire logic area_w;
  assign area_w           = (i_field != `OBCD_BOOT_NONE);
  assign o_area_en        = area_w;
  assign o_last_page      = last_page(i_field);
  assign o_page_protected = area_w && (i_page <= o_last_page);
endmodule
`default_nettype wire

// File: sim/obcd_store_model.sv
// Behavioural option byte storage, preloaded by the bench
`timescale 1ns/10ps
`default_nettype none
module obcd_store_model (
  // Clock and preload
  input  wire logic       i_clk,
  input  wire logic       i_load,
  input  wire logic [7:0] i_init_ro,
  input  wire logic [7:0] i_init_boot,
  input  wire logic [7:0] i_init_remap,
  // Writes from the decoder
  input  wire logic       i_wr_en,
  input  wire logic [1:0] i_wr_sel,
  input  wire logic [7:0] i_wr_data,
  // Stored bytes
  output logic [7:0]      o_ro,
  output logic [7:0]      o_boot,
  output logic [7:0]      o_remap
);
  // Preload wins so every run starts from the bench's chosen bytes
  always @(posedge i_clk) begin
    if (i_load) begin
      o_ro <= i_init_ro;
      o_boot <= i_init_boot;
      o_remap <= i_init_remap;
    end else if (i_wr_en) begin
      case (i_wr_sel)
        2'h0: o_ro <= i_wr_data;
        2'h1: o_boot <= i_wr_data;
        2'h2: o_remap <= i_wr_data;
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: sim/option_byte_config_decoder_tb.sv
// Random and corner-case bench for the option byte decoder
`timescale 1ns/10ps
`default_nettype none
module option_byte_config_decoder_tb;
  logic       i_clk = 1'b0;
  logic       i_reset_n = 1'b0;
  logic       load = 1'b1;
  logic [7:0] init_ro = 8'h00, init_boot = 8'h00, init_remap = 8'h00;
  logic       wr_req = 1'b0, wr_dbg = 1'b0;
  logic [1:0] wr_sel = 2'h0;
  logic [7:0] wr_data = 8'h00;
  logic [5:0] page = 6'h00;
  wire logic [7:0] st_ro, st_boot, st_remap, nv_data, c_ro, c_boot, c_rm;
  wire logic [1:0] nv_sel;
  wire logic [5:0] last;
  wire logic       nv_en, refused, valid, lock, area_en, prot;
  wire logic       s7, s6, s5, s4, s3, s2, s1, s0;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] ro_tab [4] = '{8'hAA, 8'hAB, 8'h00, 8'h55};
  logic [7:0] bt_tab [8] = '{8'h00, 8'h01, 8'h02, 8'h03,
                             8'h1F, 8'h20, 8'h3F, 8'hC5};

  obcd_store_model u_obcd_store_model (.i_clk(i_clk), .i_load(load),
    .i_init_ro(init_ro), .i_init_boot(init_boot), .i_init_remap(init_remap),
    .i_wr_en(nv_en), .i_wr_sel(nv_sel), .i_wr_data(nv_data),
    .o_ro(st_ro), .o_boot(st_boot), .o_remap(st_remap));

  obcd_top u_obcd_top (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_readout_protect_byte(st_ro), .i_boot_area_protect_byte(st_boot),
    .i_pin_remap_byte(st_remap), .i_wr_req(wr_req), .i_wr_sel(wr_sel),
    .i_wr_data(wr_data), .i_wr_via_debug(wr_dbg), .o_nv_wr_en(nv_en),
    .o_nv_wr_sel(nv_sel), .o_nv_wr_data(nv_data), .o_wr_refused(refused),
    .o_config_valid(valid), .o_readout_protect_byte(c_ro),
    .o_boot_area_protect_byte(c_boot), .o_pin_remap_byte(c_rm),
    .o_readout_lock(lock), .o_boot_area_en(area_en),
    .o_boot_last_page(last), .i_page(page), .o_page_write_protected(prot),
    .o_pd4_tone_sel(s7), .o_pb54_i2c_sel(s6), .o_pb30_timer_one_sel(s5),
    .o_pd0_clock_out_sel(s4), .o_remap_two_active(s2),
    .o_remap_three_active(s3), .o_pa3_d2_swap(s1), .o_remap_bit_zero(s0));

  initial begin
    forever #20 i_clk = ~i_clk;
  end

  task automatic results;
    $display("checks=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [5:0] exp_last(input logic [5:0] v);
    int n;
    n = 2 * int'(v) - 1;
    if (v == 6'h00) return 6'h00;
    return (n > 63) ? 6'h3F : 6'(n);
  endfunction

  task automatic wr(input logic [1:0] s, input logic [7:0] d, input logic g);
    logic ok;
    ok = (init_ro != 8'hAA) || g;
    @(posedge i_clk);
    wr_req <= 1'b1;
    wr_sel <= s;
    wr_data <= d;
    wr_dbg <= g;
    @(posedge i_clk);
    wr_req <= 1'b0;
    #1;
    chk({7'h0, nv_en}, {7'h0, ok});
    chk({7'h0, refused}, {7'h0, !ok});
    if (ok) begin
      chk({6'h0, nv_sel}, {6'h0, s});
      chk(nv_data, d);
    end
  endtask

  initial begin
    logic [5:0] p;
    logic [5:0] l;
    logic [7:0] r;
    void'($urandom(32'h2570));
    for (int i = 0; i < 24; i++) begin
      @(posedge i_clk);
      i_reset_n <= 1'b0;
      load <= 1'b1;
      init_ro <= (i < 8) ? ro_tab[i % 4]
                         : (($urandom % 2) ? 8'hAA : 8'($urandom));
      init_boot <= (i < 8) ? bt_tab[i] : 8'($urandom);
      init_remap <= 8'($urandom);
      repeat (2) @(posedge i_clk);
      #1;
      chk({7'h0, valid}, 8'h00);
      @(posedge i_clk);
      i_reset_n <= 1'b1;
      load <= 1'b0;
      repeat (8) begin
        @(posedge i_clk);
        #1;
        if (valid === 1'b1) break;
      end
      chk({7'h0, valid}, 8'h01);
      l = exp_last(init_boot[5:0]);
      r = init_remap;
      chk({7'h0, lock}, {7'h0, init_ro == 8'hAA});
      chk({7'h0, area_en}, {7'h0, l != 6'h00});
      chk({2'h0, last}, {2'h0, l});
      chk({7'h0, s7}, {7'h0, r[7]});
      chk({7'h0, s6}, {7'h0, r[6]});
      chk({7'h0, s5}, {7'h0, r[5]});
      chk({7'h0, s4}, {7'h0, r[4]});
      chk({6'h0, s3, s2}, {6'h0, r[3] & ~r[2], r[2]});
      chk({6'h0, s1, s0}, {6'h0, r[1], r[0]});
      // The last protected page and the page above it, then two random pages
      for (int k = 0; k < 4; k++) begin
        p = (k == 0) ? l : (k == 1) ? l + 6'h01 : 6'($urandom);
        @(posedge i_clk);
        page <= p;
        @(posedge i_clk);
        #1;
        chk({7'h0, prot}, {7'h0, (l != 6'h00) && (p <= l)});
      end
      wr(2'($urandom % 3), 8'($urandom), 1'b0);
      wr(2'($urandom % 3), 8'($urandom), 1'b1);
      // Storage now differs, captured settings must not follow
      chk(c_ro, init_ro);
      chk(c_boot, init_boot);
      chk(c_rm, init_remap);
    end
    results();
  end
endmodule
`default_nettype wire
